// [framer_pkg.sv]
package framer_pkg;

  localparam int          WORD_W     = 32;
  localparam int          FIFO_W     = 33;
  localparam int          FIFO_DEPTH = 4;
  localparam int          TC_W       = 96;
  localparam int          TC_USED    = 90;
  localparam int          TC_PAD     = TC_W - TC_USED;
  localparam int          CODE_MSB   = 31;
  localparam int          CODE_LSB   = 24;
  localparam int          BW_MSB     = 23;
  localparam int          BW_LSB     = 8;

  // All-ones word, and the whole words seen after it on a word boundary
  localparam logic [31:0] ONES_WORD      = 32'hFFFF_FFFF;
  localparam logic [31:0] FIELD_ONE_WORD = 32'h4000_0000;
  localparam logic [31:0] FIELD_TWO_WORD = 32'h4100_0000;
  localparam logic [31:0] END_WORD       = 32'hC0FF_FFFF;

  // Code bytes; the first block's type bytes share the first four values
  localparam logic [7:0]  CHROMA_ONE = 8'h81;
  localparam logic [7:0]  LUMA_ONE   = 8'h82;
  localparam logic [7:0]  CHROMA_TWO = 8'h83;
  localparam logic [7:0]  LUMA_TWO   = 8'h84;
  localparam logic [7:0]  ZERO_CODE  = 8'h8F;

  localparam logic [5:0]  BLOCKS     = 6'h29;
  localparam logic [5:0]  BLK_ZERO   = 6'h00;
  localparam logic [5:0]  BLK_ONE    = 6'h01;
  localparam logic [1:0]  TC_FIRST   = 2'h0;
  localparam logic [1:0]  TC_LAST    = 2'h2;
  localparam logic [1:0]  TC_STEP    = 2'h1;
  localparam logic [15:0] BW_ZERO    = 16'h0000;

  function automatic logic is_type_code(input logic [7:0] c);
    return (c == CHROMA_ONE) || (c == LUMA_ONE) ||
           (c == CHROMA_TWO) || (c == LUMA_TWO);
  endfunction

  function automatic logic is_block_code(input logic [7:0] c);
    return is_type_code(c) || (c == ZERO_CODE);
  endfunction

endpackage

// [word_fifo.sv]
`timescale 1ns/100ps
module word_fifo #(
  parameter int W     = 33,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output      logic         in_ready,
  output      logic [W-1:0] out_data,
  output      logic         out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule

// [field_framer.sv]
`timescale 1ns/100ps
// Contract
// [RL1] A field: start code, timecode, type, bin width, data, 41 blocks.
// [RL2] Any block start code may be the zero-data block code.
// [RL3] A sequence holds any number of fields, each with its start code.
// [RL4] In decode the host ends each sequence with the end code.
// [RL5] Delimiters sit on 32-bit word boundaries; search only there.
// [RL6] Field-one start code marks data of field one.
// [RL7] Field-two start code marks data of field two.
// [RL8] Either field start code resets the device's decode processing.
// [RL9] Only a field start code is needed between adjacent fields.
// [RL10] Device sets field output and SAV/EAV field bit from start code.
// [RL11] Timecode is 96 bits; device extracts or inserts it.
// [RL12] Only 90 of the 96 timecode bits carry content.
// [RL13] First block has an 8-bit type code 0x81 to 0x84, no delimiter.
// [RL14] Block codes one to four pick model and table; five is zero block.
// [RL15] Device ignores all after a zero block code until next block.
// [RL16] Bin width is a plain 16-bit unsigned 8.8 value.
// [RL17] Device never appends the end code; the host adds it.
// [RL18] Device emits field one or two start code by field parity.
module field_framer (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic [31:0] RX_DATA,
  input  wire logic        RX_VALID,
  output      logic        RX_READY,
  output      logic [31:0] DATA_OUT,
  output      logic        DATA_HEAD,
  output      logic        DATA_VALID,
  input  wire logic        DATA_READY,
  output      logic        FIELD_TWO,
  output      logic [5:0]  BLOCK_INDEX,
  output      logic [7:0]  BLOCK_TYPE,
  output      logic [15:0] BIN_WIDTH,
  output      logic        ZERO_BLOCK,
  output      logic [89:0] TIMECODE,
  output      logic        FIELD_DONE,
  output      logic        FRAME_ERR,
  output      logic        SEQ_END,
  input  wire logic [31:0] TX_IN_DATA,
  input  wire logic        TX_IN_VALID,
  output      logic        TX_IN_READY,
  input  wire logic        TX_END,
  output      logic [31:0] TX_DATA,
  output      logic        TX_VALID,
  input  wire logic        TX_READY
);
  typedef enum logic [3:0] {
    S_HUNT = 4'b0001,
    S_TC   = 4'b0010,
    S_TYPE = 4'b0100,
    S_DATA = 4'b1000
  } rx_state_t;

  typedef enum logic [2:0] {
    T_PASS = 3'b001,
    T_ONES = 3'b010,
    T_EOSW = 3'b100
  } tx_state_t;

  rx_state_t                       st_q, st_d;
  logic                            ones_q, ones_d, in_field_q, in_field_d;
  logic                            two_q, two_d, zero_q, zero_d;
  logic [5:0]                      blk_q, blk_d;
  logic [7:0]                      type_q, type_d;
  logic [15:0]                     bw_q, bw_d;
  logic [1:0]                      tcc_q, tcc_d;
  logic [framer_pkg::TC_W-1:0]     tc_q, tc_d;
  logic                            done_q, done_d, err_q, err_d;
  logic                            end_q, end_d;
  logic                            fifo_in_ready, push, push_head, take;
  logic                            field_take, end_take;
  logic [7:0]                      code;
  logic [framer_pkg::FIFO_W-1:0]   fifo_out;

  assign RX_READY    = fifo_in_ready;
  assign take        = RX_VALID && fifo_in_ready;
  assign code        = RX_DATA[framer_pkg::CODE_MSB:framer_pkg::CODE_LSB];
  // Delimiters only count right after an all-ones word
  // [RL5] word-aligned search
  assign field_take  = take && ones_q &&
                       ((RX_DATA == framer_pkg::FIELD_ONE_WORD) ||
                        (RX_DATA == framer_pkg::FIELD_TWO_WORD));
  assign end_take    = take && ones_q && (RX_DATA == framer_pkg::END_WORD);

  assign FIELD_TWO   = two_q;
  assign BLOCK_INDEX = blk_q;
  assign BLOCK_TYPE  = type_q;
  assign BIN_WIDTH   = bw_q;
  assign ZERO_BLOCK  = zero_q;
  // [RL12] keep the content bits
  assign TIMECODE    = tc_q[framer_pkg::TC_W-1:framer_pkg::TC_PAD];
  assign FIELD_DONE  = done_q;
  assign FRAME_ERR   = err_q;
  assign SEQ_END     = end_q;

  always_comb begin
    st_d       = st_q;
    ones_d     = ones_q;
    in_field_d = in_field_q;
    two_d      = two_q;
    zero_d     = zero_q;
    blk_d      = blk_q;
    type_d     = type_q;
    bw_d       = bw_q;
    tcc_d      = tcc_q;
    tc_d       = tc_q;
    done_d     = 1'b0;
    err_d      = 1'b0;
    end_d      = 1'b0;
    push       = 1'b0;
    push_head  = 1'b0;
    if (take) begin
      ones_d = (RX_DATA == framer_pkg::ONES_WORD);
      if (field_take || end_take) begin
        // [RL1] 41 blocks per field
        if (in_field_q) begin
          done_d = (blk_q == framer_pkg::BLOCKS);
          err_d  = (blk_q != framer_pkg::BLOCKS);
        end
        blk_d  = framer_pkg::BLK_ZERO;
        zero_d = 1'b0;
      end
      if (field_take) begin
        // [RL6] [RL7] [RL9] field identity, no other separator
        two_d      = (RX_DATA == framer_pkg::FIELD_TWO_WORD);
        in_field_d = 1'b1;
        tcc_d      = framer_pkg::TC_FIRST;
        st_d       = S_TC;
      end else if (end_take) begin
        end_d      = 1'b1;
        in_field_d = 1'b0;
        st_d       = S_HUNT;
      end else begin
        unique case (st_q)
          S_HUNT: begin
          end
          S_TC: begin
            // [RL11] three timecode words
            tc_d = {tc_q[framer_pkg::TC_W-framer_pkg::WORD_W-1:0], RX_DATA};
            tcc_d = tcc_q + framer_pkg::TC_STEP;
            if (tcc_q == framer_pkg::TC_LAST) begin
              st_d = S_TYPE;
            end
          end
          S_TYPE: begin
            // [RL13] type byte without delimiter
            if (framer_pkg::is_type_code(code)) begin
              type_d    = code;
              bw_d      = RX_DATA[framer_pkg::BW_MSB:framer_pkg::BW_LSB];
              push      = 1'b1;
              push_head = 1'b1;
              st_d      = S_DATA;
            end else begin
              err_d      = 1'b1;
              in_field_d = 1'b0;
              st_d       = S_HUNT;
            end
          end
          S_DATA: begin
            if (ones_q && framer_pkg::is_block_code(code)) begin
              if (blk_q == framer_pkg::BLOCKS) begin
                err_d = 1'b1;
              end else begin
                // [RL14] [RL2] model select or zero block
                blk_d     = blk_q + framer_pkg::BLK_ONE;
                type_d    = code;
                zero_d    = (code == framer_pkg::ZERO_CODE);
                // [RL16] raw 8.8 bin width
                bw_d      = zero_d ? framer_pkg::BW_ZERO :
                            RX_DATA[framer_pkg::BW_MSB:framer_pkg::BW_LSB];
                push      = 1'b1;
                push_head = 1'b1;
              end
            end else if (!ones_d && !zero_q) begin
              push = 1'b1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_q       <= S_HUNT;
      ones_q     <= 1'b0;
      in_field_q <= 1'b0;
      two_q      <= 1'b0;
      zero_q     <= 1'b0;
      blk_q      <= framer_pkg::BLK_ZERO;
      type_q     <= '0;
      bw_q       <= framer_pkg::BW_ZERO;
      tcc_q      <= framer_pkg::TC_FIRST;
      tc_q       <= '0;
      done_q     <= 1'b0;
      err_q      <= 1'b0;
      end_q      <= 1'b0;
    end else begin
      st_q       <= st_d;
      ones_q     <= ones_d;
      in_field_q <= in_field_d;
      two_q      <= two_d;
      zero_q     <= zero_d;
      blk_q      <= blk_d;
      type_q     <= type_d;
      bw_q       <= bw_d;
      tcc_q      <= tcc_d;
      tc_q       <= tc_d;
      done_q     <= done_d;
      err_q      <= err_d;
      end_q      <= end_d;
    end
  end

  word_fifo #(
    .W     (framer_pkg::FIFO_W),
    .DEPTH (framer_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLOCK),
    .rst       (RST),
    .in_data   ({push_head, RX_DATA}),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (DATA_VALID),
    .out_ready (DATA_READY)
  );
  assign DATA_HEAD = fifo_out[framer_pkg::WORD_W];
  assign DATA_OUT  = fifo_out[framer_pkg::WORD_W-1:0];

  // Transmit path to the device, with closing end code
  tx_state_t   tx_q, tx_d;
  logic [31:0] txd_q, txd_d;
  logic        txv_q, txv_d, out_free;

  assign out_free    = !txv_q || TX_READY;
  assign TX_IN_READY = (tx_q == T_PASS) && out_free;
  assign TX_DATA     = txd_q;
  assign TX_VALID    = txv_q;

  always_comb begin
    tx_d  = tx_q;
    txd_d = txd_q;
    txv_d = txv_q && !TX_READY;
    unique case (tx_q)
      T_PASS: begin
        if (TX_IN_VALID && out_free) begin
          txd_d = TX_IN_DATA;
          txv_d = 1'b1;
        end
        // [RL4] [RL17] host appends the end code
        if (TX_END) begin
          tx_d = T_ONES;
        end
      end
      T_ONES: begin
        if (out_free) begin
          txd_d = framer_pkg::ONES_WORD;
          txv_d = 1'b1;
          tx_d  = T_EOSW;
        end
      end
      T_EOSW: begin
        if (out_free) begin
          txd_d = framer_pkg::END_WORD;
          txv_d = 1'b1;
          tx_d  = T_PASS;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tx_q  <= T_PASS;
      txd_q <= '0;
      txv_q <= 1'b0;
    end else begin
      tx_q  <= tx_d;
      txd_q <= txd_d;
      txv_q <= txv_d;
    end
  end

  property p_short_field;
    @(posedge CLOCK) disable iff (RST)
    (field_take || end_take) && in_field_q && (blk_q != framer_pkg::BLOCKS)
      |=> FRAME_ERR && !FIELD_DONE;
  endproperty
  a_short_field: assert property (p_short_field) // [RL1]
    else $error("short field not flagged");

  property p_next_field;
    @(posedge CLOCK) disable iff (RST)
    field_take && in_field_q && (blk_q == framer_pkg::BLOCKS)
      |=> FIELD_DONE && (BLOCK_INDEX == framer_pkg::BLK_ZERO)
      ##3 1'b1;
  endproperty
  a_next_field: assert property (p_next_field) // [RL3]
    else $error("back to back field not accepted");

  property p_zero_block;
    @(posedge CLOCK) disable iff (RST)
    take && (st_q == S_DATA) && ones_q && !field_take && !end_take &&
      (code == framer_pkg::ZERO_CODE) && (blk_q != framer_pkg::BLOCKS)
      |=> ZERO_BLOCK && (BIN_WIDTH == framer_pkg::BW_ZERO) &&
          (BLOCK_INDEX == $past(blk_q) + framer_pkg::BLK_ONE);
  endproperty
  a_zero_block: assert property (p_zero_block) // [RL2]
    else $error("zero block code not taken");

  property p_aligned;
    @(posedge CLOCK) disable iff (RST)
    $changed(blk_q) && (blk_q != framer_pkg::BLK_ZERO) |-> $past(ones_q);
  endproperty
  a_aligned: assert property (p_aligned) // [RL5]
    else $error("block counted without preceding ones word");

  property p_field_one;
    @(posedge CLOCK) disable iff (RST)
    field_take && (RX_DATA == framer_pkg::FIELD_ONE_WORD)
      |=> !FIELD_TWO ##1 (st_q == S_TC);
  endproperty
  a_field_one: assert property (p_field_one) // [RL6]
    else $error("field one code gave wrong identity");

  property p_field_two;
    @(posedge CLOCK) disable iff (RST)
    field_take && (RX_DATA == framer_pkg::FIELD_TWO_WORD) |=> FIELD_TWO;
  endproperty
  a_field_two: assert property (p_field_two) // [RL7]
    else $error("field two code gave wrong identity");

  property p_bad_type;
    @(posedge CLOCK) disable iff (RST)
    take && (st_q == S_TYPE) && !field_take && !end_take &&
      !framer_pkg::is_type_code(code) |=> FRAME_ERR && (st_q == S_HUNT);
  endproperty
  a_bad_type: assert property (p_bad_type) // [RL13]
    else $error("bad type code not flagged");

  property p_bin_width;
    @(posedge CLOCK) disable iff (RST)
    take && (st_q == S_DATA) && ones_q && !field_take && !end_take &&
      framer_pkg::is_type_code(code) && (blk_q != framer_pkg::BLOCKS)
      |=> BIN_WIDTH == $past(RX_DATA[framer_pkg::BW_MSB:framer_pkg::BW_LSB]);
  endproperty
  a_bin_width: assert property (p_bin_width) // [RL16]
    else $error("bin width not captured");

  property p_end_code;
    @(posedge CLOCK) disable iff (RST)
    (tx_q == T_EOSW) && out_free
      |=> TX_VALID && (TX_DATA == framer_pkg::END_WORD) &&
          $past(txd_q == framer_pkg::ONES_WORD);
  endproperty
  a_end_code: assert property (p_end_code) // [RL17]
    else $error("end code not sent after ones word");

  property p_end_start;
    @(posedge CLOCK) disable iff (RST)
    TX_END && (tx_q == T_PASS) |=> (tx_q == T_ONES) && !TX_IN_READY;
  endproperty
  a_end_start: assert property (p_end_start) // [RL4]
    else $error("end request not started");

  c_field_done: cover property (@(posedge CLOCK) disable iff (RST)
    FIELD_DONE);
  c_zero_block: cover property (@(posedge CLOCK) disable iff (RST)
    $rose(ZERO_BLOCK));
  c_seq_end: cover property (@(posedge CLOCK) disable iff (RST)
    SEQ_END);
  c_end_sent: cover property (@(posedge CLOCK) disable iff (RST)
    TX_VALID && TX_READY && (TX_DATA == framer_pkg::END_WORD));
endmodule

// [codec_model.sv]
`timescale 1ns/100ps
module codec_model #(
  parameter logic [95:0] TC = 96'h0
) (
  input  wire logic        clk,
  input  wire logic        slow,
  output      logic [31:0] rx_data,
  output      logic        rx_valid,
  input  wire logic        rx_ready,
  input  wire logic [31:0] tx_data,
  input  wire logic        tx_valid,
  output      logic        tx_ready
);
  logic [31:0] q[$];
  logic [32:0] exp_q[$];
  logic [31:0] got[$];
  logic [31:0] last;
  logic        taken;
  logic        ph;

  task automatic put_word(input logic [31:0] w, input logic head,
                          input logic keep);
    q.push_back(w);
    if (keep) begin
      exp_q.push_back({head, w});
    end
  endtask

  task automatic field(input logic two, input logic [7:0] ty, input int nblk,
                       input int zpos);
    logic [7:0] c;
    // Start code restarts decode and sets field identity
    q.push_back(framer_pkg::ONES_WORD);
    q.push_back(two ? framer_pkg::FIELD_TWO_WORD :
                framer_pkg::FIELD_ONE_WORD);
    for (int k = 0; k < 3; k++) begin
      q.push_back(TC[95-32*k -: 32]);
    end
    // Type byte and bin width, no delimiter
    put_word({ty, 16'h1DDC, 8'hA5}, 1'b1, 1'b1);
    // Code byte off a delimiter is plain data
    put_word(32'h8300_00FF, 1'b0, 1'b1);
    // Block groups, zero block at zpos
    for (int b = 1; b <= nblk; b++) begin
      c = (b == zpos) ? framer_pkg::ZERO_CODE : 8'h81 + 8'(b % 4);
      q.push_back(framer_pkg::ONES_WORD);
      put_word({c, 16'(b), 8'h00}, 1'b1, 1'b1);
      put_word(32'h5A00_0000 + 32'(b), 1'b0, c != framer_pkg::ZERO_CODE);
    end
  endtask

  initial begin
    rx_data = 32'h0000_0000;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
    last = 32'h0000_0000;
    ph = 1'b0;
    forever begin
      @(posedge clk);
      // End code arrives only from the host
      if (tx_valid && tx_ready) begin
        got.push_back(tx_data);
      end
      taken = rx_valid && rx_ready;
      if (taken) begin
        last = q.pop_front();
      end
      #1;
      ph = ~ph;
      tx_ready = !(slow && ph);
      if (!rx_valid || taken) begin
        if (q.size() > 0 && !(slow && ph)) begin
          rx_valid = 1'b1;
          rx_data = q[0];
        end else begin
          rx_valid = 1'b0;
          rx_data = ~last;
        end
      end
    end
  end
endmodule

// [compressed_field_delimiter_framer_bench.sv]
`timescale 1ns/100ps
module compressed_field_delimiter_framer_bench;
  localparam logic [95:0] TC_WORDS = 96'h1357_9BDF_2468_ACE0_0F1E_2D3C;
  logic        CLOCK = 1'b0;
  logic        RST = 1'b1;
  logic [31:0] rx_data;
  logic        rx_valid;
  logic        rx_ready;
  logic [31:0] data_out;
  logic        data_head;
  logic        data_valid;
  logic        data_ready = 1'b1;
  logic        field_two;
  logic [5:0]  block_index;
  logic [7:0]  block_type;
  logic [15:0] bin_width;
  logic        zero_block;
  logic [89:0] timecode;
  logic        field_done;
  logic        frame_err;
  logic        seq_end;
  logic [31:0] tx_in_data = 32'h0000_0000;
  logic        tx_in_valid = 1'b0;
  logic        tx_in_ready;
  logic        tx_end = 1'b0;
  logic [31:0] tx_data;
  logic        tx_valid;
  logic        tx_ready;
  logic        slow = 1'b0;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          n_done = 0;
  int          n_err = 0;
  int          n_end = 0;
  logic [32:0] got_q[$];

  always #2 CLOCK = ~CLOCK;

  field_framer DUT (.CLOCK(CLOCK), .RST(RST), .RX_DATA(rx_data),
    .RX_VALID(rx_valid), .RX_READY(rx_ready), .DATA_OUT(data_out),
    .DATA_HEAD(data_head), .DATA_VALID(data_valid), .DATA_READY(data_ready),
    .FIELD_TWO(field_two), .BLOCK_INDEX(block_index),
    .BLOCK_TYPE(block_type), .BIN_WIDTH(bin_width), .ZERO_BLOCK(zero_block),
    .TIMECODE(timecode), .FIELD_DONE(field_done), .FRAME_ERR(frame_err),
    .SEQ_END(seq_end), .TX_IN_DATA(tx_in_data), .TX_IN_VALID(tx_in_valid),
    .TX_IN_READY(tx_in_ready), .TX_END(tx_end), .TX_DATA(tx_data),
    .TX_VALID(tx_valid), .TX_READY(tx_ready));

  codec_model #(.TC(TC_WORDS)) DEV (.clk(CLOCK), .slow(slow),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

  // Popped words and status pulses
  always @(posedge CLOCK) begin
    if (data_valid === 1'b1 && data_ready === 1'b1) begin
      got_q.push_back({data_head, data_out});
    end
    if (field_done === 1'b1) n_done++;
    if (frame_err === 1'b1) n_err++;
    if (seq_end === 1'b1) n_end++;
  end

  task automatic chk(input logic [95:0] g, input logic [95:0] e,
                     input string what);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, g, e);
    end
  endtask

  task automatic chk_stream;
    int n;
    n = got_q.size();
    chk(96'(n), 96'(DEV.exp_q.size()), "stream length");
    for (int i = 0; i < n && i < DEV.exp_q.size(); i++) begin
      chk(96'(got_q[i]), 96'(DEV.exp_q[i]), "stream word");
    end
    got_q.delete();
    DEV.exp_q.delete();
  endtask

  task automatic wait_idle;
    int i;
    i = 0;
    while ((DEV.q.size() > 0 || rx_valid === 1'b1) && i < 3000) begin
      @(posedge CLOCK);
      i++;
    end
    if (i >= 3000) chk(96'h1, 96'h0, "receive stalled");
    repeat (8) @(posedge CLOCK);
    #1;
  endtask

  task automatic send_end;
    DEV.q.push_back(framer_pkg::ONES_WORD);
    DEV.q.push_back(framer_pkg::END_WORD);
    wait_idle();
  endtask

  task automatic s_field_one;
    int i;
    slow = 1'b1;
    data_ready = 1'b0;
    DEV.field(1'b0, 8'h84, 41, 41);
    i = 0;
    while (rx_ready !== 1'b0 && i < 300) begin
      @(posedge CLOCK);
      i++;
    end
    #1;
    chk(96'(rx_ready), 96'h0, "fifo refuses when full");
    chk(96'(data_valid), 96'h1, "fifo holds words");
    data_ready = 1'b1;
    wait_idle();
    chk(96'(data_valid), 96'h0, "fifo drained");
    chk(96'(block_index), 96'(framer_pkg::BLOCKS), "block count");
    chk(96'(block_type), 96'(framer_pkg::ZERO_CODE), "zero code");
    chk(96'(zero_block), 96'h1, "zero flag");
    chk(96'(bin_width), 96'(framer_pkg::BW_ZERO), "zero width");
    chk(96'(field_two), 96'h0, "field one");
    chk(96'(timecode), 96'(TC_WORDS[95:6]), "timecode");
    chk_stream();
    send_end();
    chk(96'(n_done), 96'h1, "field closed");
    chk(96'(n_err), 96'h0, "no error");
    chk(96'(n_end), 96'h1, "sequence end");
    slow = 1'b0;
  endtask

  task automatic s_multi_field;
    DEV.field(1'b1, 8'h81, 3, 2);
    DEV.field(1'b0, 8'h82, 41, 20);
    DEV.field(1'b1, 8'h83, 41, 41);
    wait_idle();
    chk(96'(field_two), 96'h1, "field two");
    chk(96'(block_index), 96'(framer_pkg::BLOCKS), "block count");
    chk(96'(n_err), 96'h1, "short field");
    chk(96'(n_done), 96'h2, "back to back");
    chk_stream();
    send_end();
    chk(96'(n_done), 96'h3, "last field closed");
    chk(96'(n_end), 96'h2, "sequence end");
  endtask

  task automatic s_bad_type;
    DEV.field(1'b0, 8'h85, 2, 0);
    send_end();
    chk(96'(n_err), 96'h2, "bad type");
    chk(96'(got_q.size()), 96'h0, "nothing pushed");
    chk(96'(n_end), 96'h3, "sequence end");
    got_q.delete();
    DEV.exp_q.delete();
  endtask

  task automatic send_tx(input logic [31:0] w);
    int i;
    tx_in_data = w;
    tx_in_valid = 1'b1;
    i = 0;
    do begin
      @(posedge CLOCK);
      i++;
    end while (tx_in_ready !== 1'b1 && i < 100);
    #1;
  endtask

  task automatic s_tx_end;
    int i;
    slow = 1'b1;
    send_tx(32'h1111_2222);
    send_tx(32'h3333_4444);
    tx_in_valid = 1'b0;
    tx_end = 1'b1;
    @(posedge CLOCK);
    #1;
    tx_end = 1'b0;
    chk(96'(tx_in_ready), 96'h0, "user held off");
    i = 0;
    while (DEV.got.size() < 4 && i < 200) begin
      @(posedge CLOCK);
      i++;
    end
    chk(96'(DEV.got.size()), 96'h4, "word count");
    chk(96'(DEV.got[0]), 96'h1111_2222, "first word");
    chk(96'(DEV.got[1]), 96'h3333_4444, "second word");
    chk(96'(DEV.got[2]), 96'(framer_pkg::ONES_WORD), "end ones");
    chk(96'(DEV.got[3]), 96'(framer_pkg::END_WORD), "end code");
    slow = 1'b0;
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #300000;
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge CLOCK);
    #1 RST = 1'b0;
    @(posedge CLOCK);
    #1;
    s_field_one();
    s_multi_field();
    s_bad_type();
    s_tx_end();
    close_out();
  end
endmodule
